// ---- hdl/rxsi_pkg.sv ----
package rxsi_pkg;
	// register addresses on the host control port
	localparam logic [6:0] RXSI_ADDR_SLIP_STATUS = 7'h15; // slip status, read only
	localparam logic [6:0] RXSI_ADDR_IRQ_ENABLE1 = 7'h16; // status-2 interrupt enables
	localparam logic [6:0] RXSI_ADDR_IRQ_ENABLE2 = 7'h17; // slip interrupt enable
	// field positions
	localparam int RXSI_BIT_OUTPUT_SLIP      = 0; // output_slip_flag in slip status
	localparam int RXSI_BIT_CHANSTAT_CRC     = 7; // chanstat_crc_irq_enable
	localparam int RXSI_BIT_PARITY           = 6; // parity_irq_enable
	localparam int RXSI_BIT_VALIDITY         = 5; // validity_irq_enable
	localparam int RXSI_BIT_BIPHASE_ERR      = 4; // biphase_err_irq_enable
	localparam int RXSI_BIT_SUBCODE_CHANGE   = 3; // subcode_change_irq_enable
	localparam int RXSI_BIT_LOCK_LOSS        = 2; // lock_loss_irq_enable
	localparam int RXSI_BIT_SUBCODE_CRC      = 1; // subcode_crc_irq_enable
	localparam int RXSI_BIT_BUFFER_MOVE      = 0; // buffer_move_irq_enable
	localparam int RXSI_BIT_SLIP_IRQ_ENABLE  = 0; // slip enable inside the second mask
	// values after reset: every source masked
	localparam logic [7:0] RXSI_RESET_IRQ_ENABLE1 = 8'h00;
	localparam logic       RXSI_RESET_SLIP_ENABLE = 1'b0;
	localparam logic [7:0] RXSI_RESET_RDATA       = 8'h00;
endpackage

// ---- hdl/rxsi_slip_if.sv ----
`timescale 1ns/1ps
// slip detector hookup between the top and its slip module
interface rxsi_slip_if;
	logic slip_event;  // one-cycle slip or repeat seen by the output stage
	logic porta_src;   // port A takes the receiver output
	logic porta_slave; // port A runs as clock slave
	logic portb_src;   // port B takes the receiver output
	logic portb_slave; // port B runs as clock slave
	logic clear;       // host read of the slip status
	logic flag;        // sticky output_slip_flag
	modport top (output slip_event, porta_src, porta_slave, portb_src, portb_slave, clear,
		input flag);
	modport slip (input slip_event, porta_src, porta_slave, portb_src, portb_slave, clear,
		output flag);
endinterface

// ---- hdl/rxsi_slip.sv ----
`timescale 1ns/1ps
// qualifies slip events by port routing and holds the sticky flag
module rxsi_slip
	import rxsi_pkg::*;
(
	input wire logic  clk,    // device clock
	input wire logic  resetn, // synchronous, active low
	input wire logic  ce,     // clock enable, freezes state when low
	rxsi_slip_if.slip sl      // event, routing and flag
);
	logic next_flag; // next value of the sticky flag
	logic sel_slave; // slave mode of the port the flag belongs to
	logic qualify;   // slip counts only for a slave port fed by the receiver

	// port A wins when both take the receiver output
	always_comb begin
		if (sl.porta_src) begin
			sel_slave = sl.porta_slave;
		end else if (sl.portb_src) begin
			sel_slave = sl.portb_slave;
		end else begin
			sel_slave = 1'b0;
		end
		qualify = sel_slave;
		// a slip in the read cycle survives, so no event is lost
		next_flag = (sl.slip_event & qualify) | (sl.flag & ~sl.clear);
	end

	// flag register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sl.flag <= 1'b0;
		end else if (ce) begin
			sl.flag <= next_flag;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// a qualified slip on port A sets the flag on the next edge
	a_slip_porta_slave: assert property (ce && sl.slip_event && sl.porta_src
		&& sl.porta_slave |=> sl.flag)
		else $error("slip on slave port A not flagged");
	a_slip_portb_only: assert property (ce && sl.slip_event && !sl.porta_src
		&& sl.portb_src && sl.portb_slave |=> sl.flag)
		else $error("slip on lone port B not flagged");
	a_slip_porta_first: assert property (ce && !sl.flag && sl.porta_src
		&& !sl.porta_slave |=> !sl.flag)
		else $error("port B slip leaked while port A has priority");
	a_slip_no_route: assert property (ce && !sl.flag && !sl.porta_src
		&& !sl.portb_src |=> !sl.flag)
		else $error("slip flagged without receiver routing");
	// a qualified slip in the read cycle wins over the clear
	a_slip_set_wins: assert property (ce && sl.slip_event && sl.clear && qualify
		|=> sl.flag)
		else $error("slip lost to a same-cycle read");
	// ce low holds the flag
	a_slip_frozen: assert property (!ce |=> $stable(sl.flag))
		else $error("slip flag moved while frozen");
endmodule

// ---- hdl/rxsi_top.sv ----
`timescale 1ns/1ps
module rxsi_top
	import rxsi_pkg::*;
(
	input  wire logic       CLK,         // device clock, 40 MHz
	input  wire logic       RESETN,      // synchronous, active low
	input  wire logic       CE,          // clock enable
	input  wire logic [6:0] REG_ADDR,    // host control port address
	input  wire logic [7:0] REG_WDATA,   // write data
	input  wire logic       REG_WR,      // write strobe, one cycle
	input  wire logic       REG_RD,      // read strobe, one cycle
	output logic      [7:0] REG_RDATA,   // read data, registered
	input  wire logic [7:0] RX_STATUS,   // receiver status-2 flags
	input  wire logic       SLIP_EVENT,  // output slip or repeat pulse
	input  wire logic       PORTA_SRC,   // port A fed by the receiver
	input  wire logic       PORTA_SLAVE, // port A in slave mode
	input  wire logic       PORTB_SRC,   // port B fed by the receiver
	input  wire logic       PORTB_SLAVE, // port B in slave mode
	output logic            SLIP_FLAG,   // copy of output_slip_flag
	output logic            RX_IRQ       // receiver interrupt request
);
	logic [7:0] irq_enable1;      // enables for status-2 flags
	logic       slip_irq_enable;  // enable for the slip flag
	logic [7:0] next_irq_enable1; // next enables
	logic       next_slip_enable; // next slip enable
	logic [7:0] next_rdata;       // next read data
	logic       next_irq;         // next request
	logic       slip_hit;         // slip flag passing its enable
	logic       status_hit;       // any status-2 flag passing its enable
	logic       next_slip_copy;   // next pin copy of the slip flag

	rxsi_slip_if sif (); // link to the slip module

	assign sif.slip_event  = SLIP_EVENT;
	assign sif.porta_src   = PORTA_SRC;
	assign sif.porta_slave = PORTA_SLAVE;
	assign sif.portb_src   = PORTB_SRC;
	assign sif.portb_slave = PORTB_SLAVE;
	// a read of the slip status clears the flag; the slip module lets a same-cycle event win
	assign sif.clear = CE & REG_RD & (REG_ADDR == RXSI_ADDR_SLIP_STATUS);

	// slip qualification and the sticky flag live in their own module
	rxsi_slip u_slip (
		.clk    (CLK),
		.resetn (RESETN),
		.ce     (CE),
		.sl     (sif)
	);

	// register writes and reads
	always_comb begin
		next_irq_enable1 = irq_enable1;
		next_slip_enable = slip_irq_enable;
		next_rdata       = REG_RDATA;
		if (REG_WR) begin
			if (REG_ADDR == RXSI_ADDR_IRQ_ENABLE1) begin
				next_irq_enable1 = REG_WDATA;
			end
			if (REG_ADDR == RXSI_ADDR_IRQ_ENABLE2) begin
				next_slip_enable = REG_WDATA[RXSI_BIT_SLIP_IRQ_ENABLE];
			end
		end
		if (REG_RD) begin
			// unmapped addresses read as zero
			next_rdata = 8'h00;
			unique case (REG_ADDR)
				RXSI_ADDR_SLIP_STATUS: begin
					next_rdata[RXSI_BIT_OUTPUT_SLIP] = sif.flag;
				end
				RXSI_ADDR_IRQ_ENABLE1: begin
					next_rdata = irq_enable1;
				end
				RXSI_ADDR_IRQ_ENABLE2: begin
					next_rdata[RXSI_BIT_SLIP_IRQ_ENABLE] = slip_irq_enable;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// interrupt request: level, follows flags and enables with one cycle delay
	always_comb begin
		// status-2 sources: a level request that drops when the decoder clears its flag
		status_hit = |(RX_STATUS & irq_enable1);
		// slip source: sticky, so it stays until the host reads the status
		slip_hit   = sif.flag & slip_irq_enable;
		// one or-gate for all sources; the host reads the registers to find which
		next_irq   = status_hit | slip_hit;
		// pin copy waits one flop so SLIP_FLAG comes straight from a register
		next_slip_copy = sif.flag;
	end

	// enable and read-data group: this process only registers the decisions above
	always_ff @(posedge CLK) begin
		// reset: every source masked, read data cleared
		if (!RESETN) begin
			irq_enable1     <= RXSI_RESET_IRQ_ENABLE1;
			slip_irq_enable <= RXSI_RESET_SLIP_ENABLE;
			REG_RDATA       <= RXSI_RESET_RDATA;
		end else if (CE) begin
			// with ce low a host strobe is lost, not delayed
			irq_enable1     <= next_irq_enable1;
			slip_irq_enable <= next_slip_enable;
			REG_RDATA       <= next_rdata;
		end
	end

	// request group: the pins come from flops, so a status change cannot glitch them
	always_ff @(posedge CLK) begin
		// reset: no request, no slip shown
		if (!RESETN) begin
			RX_IRQ    <= 1'b0;
			SLIP_FLAG <= 1'b0;
		end else if (CE) begin
			// both follow their next values one edge late
			RX_IRQ    <= next_irq;
			SLIP_FLAG <= next_slip_copy;
		end
	end

	// all checks below run on CLK and, except the two reset checks, rest while RESETN is low
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// reset puts every enable and the request back to masked, whatever ce does
	a_mask_after_reset: assert property (disable iff (1'b0) !RESETN
		|=> irq_enable1 == 8'h00 && !slip_irq_enable && !RX_IRQ)
		else $error("masks not cleared by reset");
	// reset also clears the read data and the pin copy of the slip flag
	a_outputs_after_reset: assert property (disable iff (1'b0) !RESETN
		|=> REG_RDATA == 8'h00 && !SLIP_FLAG)
		else $error("outputs not cleared by reset");

	// crc source raises the request one edge later
	a_crc_irq_gate: assert property (CE && RX_STATUS[7] && irq_enable1[7] |=> RX_IRQ)
		else $error("enabled crc flag gave no request");
	// parity source likewise
	a_parity_irq_gate: assert property (CE && RX_STATUS[6] && irq_enable1[6] |=> RX_IRQ)
		else $error("enabled parity flag gave no request");
	// validity source likewise
	a_validity_irq_gate: assert property (CE && RX_STATUS[5] && irq_enable1[5] |=> RX_IRQ)
		else $error("enabled validity flag gave no request");
	// biphase and sub-code change sources likewise
	a_biphase_subcode: assert property (CE && |(RX_STATUS[4:3] & irq_enable1[4:3])
		|=> RX_IRQ)
		else $error("enabled biphase or sub-code flag gave no request");
	// lock loss, sub-code crc and buffer move gate like the rest
	a_low_status_gate: assert property (CE && |(RX_STATUS[2:0] & irq_enable1[2:0])
		|=> RX_IRQ)
		else $error("enabled low status flag gave no request");
	// any enabled status-2 source at all
	a_status_irq_any: assert property (CE && (RX_STATUS & irq_enable1) != 8'h00
		|=> RX_IRQ)
		else $error("enabled status flag gave no request");

	// a masked slip with no status source must leave the request low
	a_slip_irq_masked: assert property (CE && !slip_irq_enable
		&& (RX_STATUS & irq_enable1) == 8'h00 |=> !RX_IRQ)
		else $error("masked slip raised a request");
	// nothing enabled and set means no request
	a_irq_all_masked: assert property (CE && (RX_STATUS & irq_enable1) == 8'h00
		&& !(sif.flag && slip_irq_enable) |=> !RX_IRQ)
		else $error("request without an enabled flag");
	// an enabled slip flag raises the request on the next edge
	a_slip_irq_gate: assert property (CE && sif.flag && slip_irq_enable |=> RX_IRQ)
		else $error("enabled slip flag gave no request");

	// a write to the enables lands on the next edge
	a_enable1_write: assert property (CE && REG_WR
		&& REG_ADDR == RXSI_ADDR_IRQ_ENABLE1 |=> irq_enable1 == $past(REG_WDATA))
		else $error("enable write did not land");
	// the slip enable keeps only its own bit
	a_slip_enable_write: assert property (CE && REG_WR
		&& REG_ADDR == RXSI_ADDR_IRQ_ENABLE2
		|=> slip_irq_enable == $past(REG_WDATA[RXSI_BIT_SLIP_IRQ_ENABLE]))
		else $error("slip enable write did not land");
	// the status register takes no write and disturbs no enable
	a_status_read_only: assert property (CE && REG_WR
		&& REG_ADDR == RXSI_ADDR_SLIP_STATUS
		|=> $stable(irq_enable1) && $stable(slip_irq_enable))
		else $error("write to slip status changed an enable");

	// the slip status read shows the flag as it stood in the read cycle
	a_slip_read_back: assert property (CE && REG_RD
		&& REG_ADDR == RXSI_ADDR_SLIP_STATUS |=> REG_RDATA == {7'h00, $past(sif.flag)})
		else $error("slip status read wrong");
	// the enables read back as stored, old value when written in the same cycle
	a_enable1_read: assert property (CE && REG_RD
		&& REG_ADDR == RXSI_ADDR_IRQ_ENABLE1 |=> REG_RDATA == $past(irq_enable1))
		else $error("enable read back wrong");
	// the slip enable reads in bit 0, the rest zero
	a_slip_enable_read: assert property (CE && REG_RD
		&& REG_ADDR == RXSI_ADDR_IRQ_ENABLE2
		|=> REG_RDATA == {7'h00, $past(slip_irq_enable)})
		else $error("slip enable read back wrong");
	// addresses outside the map read as zero
	a_unmapped_read: assert property (CE && REG_RD && REG_ADDR != RXSI_ADDR_SLIP_STATUS
		&& REG_ADDR != RXSI_ADDR_IRQ_ENABLE1 && REG_ADDR != RXSI_ADDR_IRQ_ENABLE2
		|=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	// read data stands until the next read
	a_rdata_holds: assert property (CE && !REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");

	// ce low freezes every flop, so nothing moves on the following edge
	a_ce_freeze: assert property (!CE |=> $stable(irq_enable1) && $stable(slip_irq_enable)
		&& $stable(REG_RDATA) && $stable(RX_IRQ) && $stable(SLIP_FLAG))
		else $error("state moved while ce was low");
endmodule

// ---- tb/rxsi_host.sv ----
`timescale 1ns/1ps
// host side of the control port: strobes change on falling edges, one cycle each
module rxsi_host (
	input  wire logic       clk,   // device clock
	output logic      [6:0] addr,  // register address
	output logic      [7:0] wdata, // write data
	output logic            wr,    // write strobe
	output logic            rd,    // read strobe
	input  wire logic [7:0] rdata  // registered read data
);
	// idle bus at time zero
	initial begin
		addr = 7'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// write: strobe spans exactly one taking edge
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		wdata = ~d; // stale data must never be relied on
	endtask
	// read data is registered, so it is settled one falling edge later
	task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
// self-checking bench for slip status and receiver interrupt enables
module tb
	import rxsi_pkg::*;
;
	logic       clk = 1'b0;   // 40 MHz device clock
	logic       resetn = 1'b0; // synchronous reset, active low
	logic       ce = 1'b1;    // clock enable
	logic       slip_ev = 1'b0; // slip pulse from the output stage
	logic       a_src = 1'b0, a_slv = 1'b0, b_src = 1'b0, b_slv = 1'b0; // routing
	logic [7:0] rx_status = 8'h00; // status-2 flags
	logic [6:0] addr;          // bus address
	logic [7:0] wdata, rdata, rd_val; // bus data
	logic       wr, rd, slip_flag, rx_irq; // strobes and outputs
	int         n_mismatch = 0, total_checks = 0; // tallies
	// routing table: port A fed, A slave, port B fed, B slave, expected flag
	logic [4:0] route [6] = '{5'b11001, 5'b10000, 5'b00111, 5'b10110, 5'b11101, 5'b01010};
	// free-running clock, 25 ns period
	always #12.5 clk = ~clk;
	rxsi_top DUT (.CLK(clk), .RESETN(resetn), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_STATUS(rx_status),
		.SLIP_EVENT(slip_ev), .PORTA_SRC(a_src), .PORTA_SLAVE(a_slv), .PORTB_SRC(b_src),
		.PORTB_SLAVE(b_slv), .SLIP_FLAG(slip_flag), .RX_IRQ(rx_irq));
	rxsi_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	// compare and tally; unknowns never match
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		host.read_reg(RXSI_ADDR_IRQ_ENABLE1, rd_val);
		check(rd_val, 8'h00, "enable1 reset");
		host.read_reg(RXSI_ADDR_IRQ_ENABLE2, rd_val);
		check(rd_val, 8'h00, "enable2 reset");
		host.write_reg(RXSI_ADDR_SLIP_STATUS, 8'hff);
		host.read_reg(RXSI_ADDR_SLIP_STATUS, rd_val);
		check(rd_val, 8'h00, "status read only");
		host.read_reg(7'h20, rd_val);
		check(rd_val, 8'h00, "unmapped read");
		$display("test registers done");
		// each enable bit gates only its own flag
		for (int i = 0; i < 8; i++) begin
			host.write_reg(RXSI_ADDR_IRQ_ENABLE1, 8'h01 << i);
			host.read_reg(RXSI_ADDR_IRQ_ENABLE1, rd_val);
			check(rd_val, 8'h01 << i, "enable1 readback");
			rx_status = ~(8'h01 << i);
			repeat (2) @(negedge clk);
			check(8'(rx_irq), 8'h00, "masked irq");
			rx_status = 8'h01 << i;
			repeat (2) @(negedge clk);
			check(8'(rx_irq), 8'h01, "enabled irq");
		end
		host.write_reg(RXSI_ADDR_IRQ_ENABLE1, 8'h00);
		rx_status = 8'hff;
		repeat (2) @(negedge clk);
		check(8'(rx_irq), 8'h00, "all masked");
		rx_status = 8'h00;
		// ce low: a write to the enables is dropped
		ce = 1'b0;
		host.write_reg(RXSI_ADDR_IRQ_ENABLE1, 8'hff);
		ce = 1'b1;
		host.read_reg(RXSI_ADDR_IRQ_ENABLE1, rd_val);
		check(rd_val, 8'h00, "write frozen by ce");
		$display("test masks done");
		// slip routing, first with the slip interrupt enabled, then masked
		for (int e = 1; e >= 0; e--) begin
			host.write_reg(RXSI_ADDR_IRQ_ENABLE2, 8'(e));
			foreach (route[i]) begin
				{a_src, a_slv, b_src, b_slv} = route[i][4:1];
				slip_ev = 1'b1;
				@(negedge clk);
				slip_ev = 1'b0;
				repeat (2) @(negedge clk);
				check(8'(slip_flag), 8'(route[i][0]), "slip flag");
				check(8'(rx_irq), 8'(route[i][0] & e[0]), "slip irq");
				host.read_reg(RXSI_ADDR_SLIP_STATUS, rd_val);
				check(rd_val, 8'(route[i][0]), "slip status");
				repeat (2) @(negedge clk);
			end
		end
		// a slip in the cycle of the status read survives the read
		{a_src, a_slv, b_src, b_slv} = 4'hc;
		fork
			host.read_reg(RXSI_ADDR_SLIP_STATUS, rd_val);
			begin
				@(negedge clk);
				slip_ev = 1'b1;
				@(negedge clk);
				slip_ev = 1'b0;
			end
		join
		check(rd_val, 8'h00, "status before slip");
		host.read_reg(RXSI_ADDR_SLIP_STATUS, rd_val);
		check(rd_val, 8'h01, "slip kept over read");
		// a second reset in mid-run masks everything again
		host.write_reg(RXSI_ADDR_IRQ_ENABLE1, 8'h5a);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		host.read_reg(RXSI_ADDR_IRQ_ENABLE1, rd_val);
		check(rd_val, 8'h00, "enable1 after reset");
		$display("test slip done");
		results();
	end
	// watchdog: the tests need well under 2000 cycles
	initial begin
		#50000;
		n_mismatch++;
		results();
	end
endmodule
